// ==== hw/cpu_bit_branch_exec.sv ====
// carry bit operations and branch execution behind an AHB-Lite slave
//
// Overview of operation
// - carry_xor_bit sets the carry to carry XOR the selected operand bit.
// - carry_xor_inverted_bit sets carry to carry XOR the inverted bit.
// - inverting bit operations take the bit number from the immediate only.
// - bit_load_to_carry copies the selected operand bit into the carry.
// - inverted_bit_load_to_carry puts the inverted bit into the carry.
// - carry_store_to_bit writes carry into the bit, other bits kept.
// - inverted_carry_store_to_bit writes the inverted carry into the bit.
// - a conditional branch loads the target only when its condition holds.
// - always, never, higher, lower_or_same, carry clear/set conditions.
// - equal, overflow, sign and signed compare conditions.
// - unconditional_jump always loads the pc with the operand address.
// - absolute_subroutine_call jumps to the operand address.
// - relative_subroutine_call jumps to the following address plus a signed displacement.
// - the return resumes at the address saved by the latest call.
// - other bit operations take the bit from immediate or register bits.
`timescale 1ns/1ps
`include "cpu_bit_branch_defs.svh"
module cpu_bit_branch_exec #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [15:0] pc_out,
  output logic carry_out
);
  import cpu_bb_pkg::*;

  function automatic logic cond_true(input cond_t cc, input ccr_t f);
    logic nv;
    nv = f.n ^ f.v;
    unique case (cc)
      CC_BRANCH_ALWAYS: cond_true = 1'b1;
      CC_BRANCH_NEVER: cond_true = 1'b0;
      CC_BRANCH_HIGHER: cond_true = ~(f.c | f.z);
      CC_BRANCH_LOWER_OR_SAME: cond_true = f.c | f.z;
      CC_BRANCH_CARRY_CLEAR: cond_true = ~f.c;
      CC_BRANCH_CARRY_SET: cond_true = f.c;
      CC_BRANCH_NOT_EQUAL: cond_true = ~f.z;
      CC_BRANCH_EQUAL: cond_true = f.z;
      CC_BRANCH_OVERFLOW_CLEAR: cond_true = ~f.v;
      CC_BRANCH_OVERFLOW_SET: cond_true = f.v;
      CC_BRANCH_PLUS: cond_true = ~f.n;
      CC_BRANCH_MINUS: cond_true = f.n;
      CC_BRANCH_GREATER_OR_EQUAL: cond_true = ~nv;
      CC_BRANCH_LESS_THAN: cond_true = nv;
      CC_BRANCH_GREATER_THAN: cond_true = ~(f.z | nv);
      CC_BRANCH_LESS_OR_EQUAL: cond_true = f.z | nv;
    endcase
  endfunction : cond_true

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // bus phase state
  logic [7:0] addr_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic hready_reg;
  logic [31:0] hrdata_reg;

  // programmer visible state
  cmd_t cmd_reg;
  logic [7:0] operand_reg;
  logic [7:0] bitsel_reg;
  logic [15:0] target_reg;
  logic [15:0] pc_reg;
  ccr_t ccr_reg;
  logic [7:0] result_reg;
  logic taken_reg;
  logic err_reg;

  logic addr_phase;
  logic wr_cmd;
  cmd_t cmd_next;
  logic carry_next;
  logic [7:0] byte_next;
  logic writes_carry;
  logic writes_byte;
  logic [15:0] pc_step;
  logic [15:0] pc_next;
  logic taken_next;
  logic push;
  logic pop;
  logic err_event;
  logic [15:0] stack_top;
  logic stack_empty;
  logic stack_full;
  logic [7:0] stack_depth;
  logic [31:0] rd_next;

  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_cmd = wr_pend_reg && hit(addr_reg, `OFS_CMD);
  assign cmd_next = cmd_t'(hwdata[`CMD_W-1:0]);
  assign pc_step = pc_reg + `INSTR_STEP;

  assign hreadyout = hready_reg;
  assign hrdata = hrdata_reg;
  assign pc_out = pc_reg;
  assign carry_out = ccr_reg.c;

  bit_carry_unit u_bits (
    .cmd(cmd_next),
    .operand(operand_reg),
    .bitsel(bitsel_reg),
    .carry(ccr_reg.c),
    .carry_next(carry_next),
    .byte_next(byte_next),
    .writes_carry(writes_carry),
    .writes_byte(writes_byte)
  );

  return_stack #(
    .DEPTH(STACK_DEPTH),
    .AW(`PC_W)
  ) u_stack (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .push(push),
    .pop(pop),
    .push_data(pc_step),
    .top(stack_top),
    .empty(stack_empty),
    .full(stack_full),
    .depth(stack_depth)
  );

  // next pc, stack traffic and fault detection for one command
  always_comb begin
    pc_next = pc_step;
    taken_next = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    err_event = 1'b0;
    if (wr_cmd) begin
      unique case (cmd_next.op)
        OP_BRANCH_COND: begin
          if (cond_true(cmd_next.cond, ccr_reg)) begin
            pc_next = target_reg;
            taken_next = 1'b1;
          end
        end
        OP_UNCONDITIONAL_JUMP: begin
          pc_next = target_reg;
          taken_next = 1'b1;
        end
        OP_ABSOLUTE_SUBROUTINE_CALL: begin
          if (stack_full) begin
            err_event = 1'b1;
          end else begin
            push = 1'b1;
            pc_next = target_reg;
            taken_next = 1'b1;
          end
        end
        OP_RELATIVE_SUBROUTINE_CALL: begin
          if (stack_full) begin
            err_event = 1'b1;
          end else begin
            push = 1'b1;
            // displacement is a signed byte added to the following address
            pc_next = pc_step + {{8{target_reg[7]}}, target_reg[7:0]};
            taken_next = 1'b1;
          end
        end
        OP_SUBROUTINE_RETURN: begin
          if (stack_empty) begin
            err_event = 1'b1;
          end else begin
            pop = 1'b1;
            pc_next = stack_top;
            taken_next = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // read data mux
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (addr_reg)
      `OFS_CMD: rd_next = {20'h00000, cmd_reg};
      `OFS_OPERAND: rd_next = {24'h000000, operand_reg};
      `OFS_BITSEL: rd_next = {24'h000000, bitsel_reg};
      `OFS_TARGET: rd_next = {16'h0000, target_reg};
      `OFS_PC: rd_next = {16'h0000, pc_reg};
      `OFS_CCR: rd_next = {28'h0000000, ccr_reg};
      `OFS_RESULT: rd_next = {24'h000000, result_reg};
      `OFS_STATUS: begin
        rd_next[`STATUS_TAKEN_BIT] = taken_reg;
        rd_next[`STATUS_ERR_BIT] = err_reg;
        rd_next[`STATUS_EMPTY_BIT] = stack_empty;
        rd_next[`STATUS_FULL_BIT] = stack_full;
        rd_next[`STATUS_DEPTH_LSB +: 8] = stack_depth;
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // address phase capture; reads get one wait state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hready_reg <= 1'b1;
    end else if (ce) begin
      if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        hready_reg <= 1'b1;
      end else if (addr_phase) begin
        addr_reg <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
        wr_pend_reg <= hwrite;
        rd_pend_reg <= !hwrite;
        hready_reg <= hwrite;
      end else begin
        wr_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (ce && rd_pend_reg) begin
      hrdata_reg <= rd_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_reg <= cmd_t'(`RST_CMD);
      operand_reg <= `RST_BYTE;
      bitsel_reg <= `RST_BYTE;
      target_reg <= `RST_PC;
    end else if (ce && wr_pend_reg) begin
      if (hit(addr_reg, `OFS_CMD)) begin
        cmd_reg <= cmd_next;
      end
      if (hit(addr_reg, `OFS_OPERAND)) begin
        operand_reg <= hwdata[7:0];
      end
      if (hit(addr_reg, `OFS_BITSEL)) begin
        bitsel_reg <= hwdata[7:0];
      end
      if (hit(addr_reg, `OFS_TARGET)) begin
        target_reg <= hwdata[15:0];
      end
    end
  end

  // program counter: direct write or command outcome
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_reg <= `RST_PC;
      taken_reg <= 1'b0;
    end else if (ce) begin
      if (wr_cmd) begin
        pc_reg <= pc_next;
        taken_reg <= taken_next;
      end else if (wr_pend_reg && hit(addr_reg, `OFS_PC)) begin
        pc_reg <= hwdata[15:0];
      end
    end
  end

  // flags: bit operations own the carry, software may load all four
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ccr_reg <= ccr_t'(`RST_CCR);
    end else if (ce) begin
      if (wr_cmd && writes_carry) begin
        ccr_reg.c <= carry_next;
      end else if (wr_pend_reg && hit(addr_reg, `OFS_CCR)) begin
        ccr_reg <= ccr_t'(hwdata[3:0]);
      end
    end
  end

  // stored byte; the operand register is not touched by a store
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result_reg <= `RST_BYTE;
    end else if (ce && wr_cmd && writes_byte) begin
      result_reg <= byte_next;
    end
  end

  // sticky stack fault, write one to clear, a new fault wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_reg <= 1'b0;
    end else if (ce) begin
      if (err_event) begin
        err_reg <= 1'b1;
      end else if (wr_pend_reg && hit(addr_reg, `OFS_STATUS) &&
                   hwdata[`STATUS_ERR_BIT]) begin
        err_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

endmodule : cpu_bit_branch_exec

// ==== include/cpu_bit_branch_defs.svh ====
// offsets, reset values and step constants of the bit and branch unit
`ifndef CPU_BIT_BRANCH_DEFS_SVH
`define CPU_BIT_BRANCH_DEFS_SVH

`define OFS_CMD 8'h00
`define OFS_OPERAND 8'h04
`define OFS_BITSEL 8'h08
`define OFS_TARGET 8'h0C
`define OFS_PC 8'h10
`define OFS_CCR 8'h14
`define OFS_RESULT 8'h18
`define OFS_STATUS 8'h1C

`define CMD_W 12
`define PC_W 16
`define RST_PC 16'h0000
`define RST_CCR 4'h0
`define RST_BYTE 8'h00
`define RST_CMD 12'h000
`define INSTR_STEP 16'h0002
`define STATUS_TAKEN_BIT 0
`define STATUS_ERR_BIT 1
`define STATUS_EMPTY_BIT 2
`define STATUS_FULL_BIT 3
`define STATUS_DEPTH_LSB 8

`endif

// ==== include/cpu_bb_pkg.sv ====
// types shared by the bit and branch unit
package cpu_bb_pkg;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_CARRY_XOR_BIT = 4'h1,
    OP_CARRY_XOR_INVERTED_BIT = 4'h2,
    OP_BIT_LOAD_TO_CARRY = 4'h3,
    OP_INVERTED_BIT_LOAD_TO_CARRY = 4'h4,
    OP_CARRY_STORE_TO_BIT = 4'h5,
    OP_INVERTED_CARRY_STORE_TO_BIT = 4'h6,
    OP_BRANCH_COND = 4'h7,
    OP_UNCONDITIONAL_JUMP = 4'h8,
    OP_ABSOLUTE_SUBROUTINE_CALL = 4'h9,
    OP_RELATIVE_SUBROUTINE_CALL = 4'hA,
    OP_SUBROUTINE_RETURN = 4'hB,
    OP_RSVD_C = 4'hC,
    OP_RSVD_D = 4'hD,
    OP_RSVD_E = 4'hE,
    OP_RSVD_F = 4'hF
  } op_t;

  typedef enum logic [3:0] {
    CC_BRANCH_ALWAYS = 4'h0,
    CC_BRANCH_NEVER = 4'h1,
    CC_BRANCH_HIGHER = 4'h2,
    CC_BRANCH_LOWER_OR_SAME = 4'h3,
    CC_BRANCH_CARRY_CLEAR = 4'h4,
    CC_BRANCH_CARRY_SET = 4'h5,
    CC_BRANCH_NOT_EQUAL = 4'h6,
    CC_BRANCH_EQUAL = 4'h7,
    CC_BRANCH_OVERFLOW_CLEAR = 4'h8,
    CC_BRANCH_OVERFLOW_SET = 4'h9,
    CC_BRANCH_PLUS = 4'hA,
    CC_BRANCH_MINUS = 4'hB,
    CC_BRANCH_GREATER_OR_EQUAL = 4'hC,
    CC_BRANCH_LESS_THAN = 4'hD,
    CC_BRANCH_GREATER_THAN = 4'hE,
    CC_BRANCH_LESS_OR_EQUAL = 4'hF
  } cond_t;

  // command word layout, msb first
  typedef struct packed {
    logic bit_from_reg;
    logic [2:0] imm_bit;
    cond_t cond;
    op_t op;
  } cmd_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } ccr_t;

endpackage : cpu_bb_pkg

// ==== hw/bit_carry_unit.sv ====
// carry-flag bit operations on one operand byte
`timescale 1ns/1ps
module bit_carry_unit (
  input cpu_bb_pkg::cmd_t cmd,
  input logic [7:0] operand,
  input logic [7:0] bitsel,
  input logic carry,
  output logic carry_next,
  output logic [7:0] byte_next,
  output logic writes_carry,
  output logic writes_byte
);
  import cpu_bb_pkg::*;

  logic inverting;
  logic [2:0] pos;
  logic sel_bit;
  logic [7:0] mask;

  always_comb begin
    inverting = (cmd.op == OP_CARRY_XOR_INVERTED_BIT) ||
                (cmd.op == OP_INVERTED_BIT_LOAD_TO_CARRY) ||
                (cmd.op == OP_INVERTED_CARRY_STORE_TO_BIT);
    // inverting forms take the immediate only
    if (inverting || !cmd.bit_from_reg) begin
      pos = cmd.imm_bit;
    end else begin
      pos = bitsel[2:0];
    end
    sel_bit = operand[pos];
    mask = 8'h01 << pos;
    carry_next = carry;
    byte_next = operand;
    writes_carry = 1'b0;
    writes_byte = 1'b0;
    unique case (cmd.op)
      OP_CARRY_XOR_BIT: begin
        carry_next = carry ^ sel_bit;
        writes_carry = 1'b1;
      end
      OP_CARRY_XOR_INVERTED_BIT: begin
        carry_next = carry ^ ~sel_bit;
        writes_carry = 1'b1;
      end
      OP_BIT_LOAD_TO_CARRY: begin
        carry_next = sel_bit;
        writes_carry = 1'b1;
      end
      OP_INVERTED_BIT_LOAD_TO_CARRY: begin
        carry_next = ~sel_bit;
        writes_carry = 1'b1;
      end
      OP_CARRY_STORE_TO_BIT: begin
        byte_next = (operand & ~mask) | ({8{carry}} & mask);
        writes_byte = 1'b1;
      end
      OP_INVERTED_CARRY_STORE_TO_BIT: begin
        byte_next = (operand & ~mask) | ({8{~carry}} & mask);
        writes_byte = 1'b1;
      end
      default: begin
      end
    endcase
  end

endmodule : bit_carry_unit

// ==== hw/return_stack.sv ====
// return address stack for subroutine calls
`timescale 1ns/1ps
module return_stack #(
  parameter int DEPTH = 8,
  parameter int AW = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic [AW-1:0] push_data,
  output logic [AW-1:0] top,
  output logic empty,
  output logic full,
  output logic [7:0] depth
);
  logic [AW-1:0] mem [DEPTH];
  logic [7:0] count_reg;

  assign empty = (count_reg == 8'h00);
  assign full = (count_reg == 8'(DEPTH));
  assign depth = count_reg;
  assign top = empty ? '0 : mem[count_reg[$clog2(DEPTH)-1:0] - 1'b1];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_reg <= 8'h00;
    end else if (ce) begin
      if (push && !full) begin
        count_reg <= count_reg + 8'h01;
      end else if (pop && !empty) begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce && push && !full) begin
      mem[count_reg[$clog2(DEPTH)-1:0]] <= push_data;
    end
  end

endmodule : return_stack

// ==== verif/cpu_bit_branch_exec_checker.sv ====
// port assertions for the bit and branch unit
`timescale 1ns/1ps
`include "cpu_bit_branch_defs.svh"
module cpu_bit_branch_exec_checker #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [15:0] pc_out,
  input wire logic carry_out
);
  import cpu_bb_pkg::*;
  logic wr_q, sel_bit, exec;
  logic [7:0] a_q, opnd_q;
  logic [15:0] tgt_q;
  cmd_t c;
  assign c = hwdata[11:0];
  assign sel_bit = opnd_q[c.imm_bit];
  // command executes at the write data-phase edge
  assign exec = wr_q & hready & ce & (a_q == `OFS_CMD);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_q <= 1'b0;
      a_q <= 8'h00;
    end else if (ce & hready) begin
      wr_q <= hsel & htrans[1] & hwrite & (haddr[31:8] == 24'h000000);
      a_q <= haddr[7:0];
    end
  end

  // shadow copies of operand and target registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opnd_q <= 8'h00;
      tgt_q <= 16'h0000;
    end else if (wr_q & hready & ce) begin
      if (a_q == `OFS_OPERAND) opnd_q <= hwdata[7:0];
      if (a_q == `OFS_TARGET) tgt_q <= hwdata[15:0];
    end
  end

  a_bit_step:
    assert property (exec && c.op inside {[4'h1:4'h6]}
      |=> pc_out == $past(pc_out) + `INSTR_STEP)
    else $error("bit op pc step");
  a_xor_carry:
    assert property (exec && c.op == OP_CARRY_XOR_BIT && !c.bit_from_reg
      |=> carry_out == ($past(carry_out) ^ $past(sel_bit)))
    else $error("carry xor wrong");
  a_xor_inverted:
    assert property (exec && c.op == OP_CARRY_XOR_INVERTED_BIT
      |=> carry_out == ($past(carry_out) ^ !$past(sel_bit)))
    else $error("carry xor inverted wrong");
  a_load_carry:
    assert property (exec && c.op == OP_BIT_LOAD_TO_CARRY && !c.bit_from_reg
      |=> carry_out == $past(sel_bit))
    else $error("bit load wrong");
  a_load_inverted:
    assert property (exec && c.op == OP_INVERTED_BIT_LOAD_TO_CARRY
      |=> carry_out != $past(sel_bit))
    else $error("inverted bit load wrong");
  a_store_keeps_carry:
    assert property (exec && c.op inside {[4'h5:4'h6]} |=> $stable(carry_out))
    else $error("store changed carry");
  a_jump_target:
    assert property (exec && c.op == OP_UNCONDITIONAL_JUMP |=> pc_out == tgt_q)
    else $error("jump target wrong");
  a_always_taken:
    assert property (exec && c.op == OP_BRANCH_COND
      && c.cond == CC_BRANCH_ALWAYS |=> pc_out == tgt_q)
    else $error("branch always not taken");
  a_never_falls:
    assert property (exec && c.op == OP_BRANCH_COND && c.cond == CC_BRANCH_NEVER
      |=> pc_out == $past(pc_out) + `INSTR_STEP)
    else $error("branch never taken");
endmodule : cpu_bit_branch_exec_checker

bind cpu_bit_branch_exec cpu_bit_branch_exec_checker #(
  .STACK_DEPTH(STACK_DEPTH)
) checker_inst (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .pc_out(pc_out), .carry_out(carry_out)
);

// ==== verif/tb.sv ====
// self-checking bench for the bit and branch unit
`timescale 1ns/1ps
`include "cpu_bit_branch_defs.svh"
module tb;
  import cpu_bb_pkg::*;
  typedef struct {
    logic [11:0] cmd;
    logic [3:0] ccr;
    logic [7:0] opnd;
    logic [7:0] bsel;
    logic ec;
    logic [7:0] eres;
  } row_t;
  logic sys_clk, rst, ce, hsel, hwrite, hready, hreadyout, hresp, carry_out;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] pc_out;
  int bad_count, tests_run;
  row_t rows[10];
  assign hready = hreadyout;

  cpu_bit_branch_exec #(.STACK_DEPTH(2)) cpu_bit_branch_exec_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .pc_out(pc_out), .carry_out(carry_out)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // single word transfer; read data lands in q
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer

  task flow(input logic [3:0] op, input logic [15:0] e);
    xfer(`OFS_CMD, 1'b1, {28'h0, op});
    xfer(`OFS_PC, 1'b0, 32'h0);
    chk("flow pc", {16'h0, e}, q);
    chk("pc_out", {16'h0, e}, {16'h0, pc_out});
  endtask : flow

  task run_bit(input row_t r);
    xfer(`OFS_CCR, 1'b1, {28'h0, r.ccr});
    xfer(`OFS_OPERAND, 1'b1, {24'h0, r.opnd});
    xfer(`OFS_BITSEL, 1'b1, {24'h0, r.bsel});
    xfer(`OFS_PC, 1'b1, 32'h0100);
    xfer(`OFS_CMD, 1'b1, {20'h0, r.cmd});
    xfer(`OFS_PC, 1'b0, 32'h0);
    chk("bit op pc", {16'h0, 16'h0100 + `INSTR_STEP}, q);
    xfer(`OFS_CCR, 1'b0, 32'h0);
    chk("ccr", {28'h0, r.ccr[3:1], r.ec}, q);
    chk("carry_out", {31'h0, r.ec}, {31'h0, carry_out});
    if (r.cmd[3:0] > 4'h4) begin
      xfer(`OFS_RESULT, 1'b0, 32'h0);
      chk("result", {24'h0, r.eres}, q);
    end
  endtask : run_bit

  function automatic logic cond_ok(input logic [3:0] cc, input logic [3:0] f);
    logic n, z, v, c;
    {n, z, v, c} = f;
    case (cc)
      4'h0: return 1'b1;
      4'h1: return 1'b0;
      4'h2: return !(c | z);
      4'h3: return c | z;
      4'h4: return !c;
      4'h5: return c;
      4'h6: return !z;
      4'h7: return z;
      4'h8: return !v;
      4'h9: return v;
      4'hA: return !n;
      4'hB: return n;
      4'hC: return !(n ^ v);
      4'hD: return n ^ v;
      4'hE: return !(z | (n ^ v));
      default: return z | (n ^ v);
    endcase
  endfunction : cond_ok

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    bad_count = 0;
    tests_run = 0;
    rows = '{
      '{12'h301, 4'hB, 8'h08, 8'h00, 1'b0, 8'h00},
      '{12'h801, 4'h6, 8'h20, 8'hFD, 1'b1, 8'h00},
      '{12'hF72, 4'h0, 8'h80, 8'h00, 1'b0, 8'h00},
      '{12'h253, 4'h0, 8'h04, 8'h00, 1'b1, 8'h00},
      '{12'h803, 4'hF, 8'h7F, 8'h07, 1'b0, 8'h00},
      '{12'hC04, 4'h0, 8'hEF, 8'h01, 1'b1, 8'h00},
      '{12'h615, 4'h1, 8'h00, 8'h00, 1'b1, 8'h40},
      '{12'h805, 4'hE, 8'hFF, 8'h02, 1'b0, 8'hFB},
      '{12'hE06, 4'h9, 8'hFF, 8'h00, 1'b1, 8'hBF},
      '{12'h006, 4'h0, 8'h00, 8'h00, 1'b0, 8'h01}};
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("pc_out reset", 32'h0, {16'h0, pc_out});
    chk("carry reset", 32'h0, {31'h0, carry_out});
    xfer(`OFS_CCR, 1'b0, 32'h0);
    chk("ccr reset", 32'h0, q);
    xfer(8'h20, 1'b1, 32'hFFFFFFFF);
    xfer(8'h20, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    foreach (rows[i]) begin
      run_bit(rows[i]);
    end
    xfer(`OFS_TARGET, 1'b1, 32'h0200);
    for (int f = 0; f < 16; f++) begin
      for (int cc = 0; cc < 16; cc++) begin
        xfer(`OFS_CCR, 1'b1, 32'(f));
        xfer(`OFS_PC, 1'b1, 32'h0100);
        xfer(`OFS_CMD, 1'b1, {24'h0, 4'(cc), 4'h7});
        xfer(`OFS_PC, 1'b0, 32'h0);
        chk("branch pc", cond_ok(4'(cc), 4'(f)) ? 32'h0200 : 32'h0102, q);
      end
    end
    xfer(`OFS_PC, 1'b1, 32'h1000);
    xfer(`OFS_TARGET, 1'b1, 32'h2468);
    flow(4'h9, 16'h2468);
    xfer(`OFS_TARGET, 1'b1, 32'h00F0);
    flow(4'hA, 16'h245A);
    xfer(`OFS_STATUS, 1'b0, 32'h0);
    chk("status full", 32'h0208, q & 32'hFF0E);
    flow(4'h9, 16'h245C);
    flow(4'hB, 16'h246A);
    flow(4'hB, 16'h1002);
    flow(4'hB, 16'h1004);
    xfer(`OFS_STATUS, 1'b0, 32'h0);
    chk("status fault", 32'h0006, q & 32'hFF0E);
    xfer(`OFS_STATUS, 1'b1, 32'h2);
    xfer(`OFS_STATUS, 1'b0, 32'h0);
    chk("status clear", 32'h0004, q & 32'hFF0E);
    xfer(`OFS_TARGET, 1'b1, 32'hBEEE);
    flow(4'h8, 16'hBEEE);
    xfer(`OFS_STATUS, 1'b0, 32'h0);
    chk("taken", 32'h1, q & 32'h1);
    chk("hresp", 32'h0, {31'h0, hresp});
    summarize();
  end
endmodule : tb
